// [twx_params.svh]
// constants for the table write / test-skip / xor execution block
`ifndef TWX_PARAMS_SVH
`define TWX_PARAMS_SVH

// register byte offsets on the axi4-lite slave
`define TWX_OFF_INSTR 8'h00
`define TWX_OFF_NEXT 8'h04
`define TWX_OFF_WORKING_REGISTER 8'h08
`define TWX_OFF_BANK_SELECT 8'h0C
`define TWX_OFF_PTR 8'h10
`define TWX_OFF_TABLE_BYTE_LATCH 8'h14
`define TWX_OFF_CTRL 8'h18
`define TWX_OFF_STATUS 8'h1C
`define TWX_OFF_HOLD 8'h20
`define TWX_OFF_FADDR 8'h24
`define TWX_OFF_FDATA 8'h28

// field positions
`define TWX_NEXT_TWO_BIT 16
`define TWX_CTRL_LONG_BIT 0
`define TWX_ST_BUSY_BIT 0
`define TWX_ST_N_BIT 1
`define TWX_ST_Z_BIT 2
`define TWX_ST_SKIP_BIT 3
`define TWX_ST_ILL_BIT 4
`define TWX_ST_CYC_LSB 8
`define TWX_DEST_BIT 9
`define TWX_ACC_BIT 8

// opcode masks and match codes
`define TWX_TABLE_WRITE_MASK 16'hFFFC
`define TWX_TABLE_WRITE_CODE 16'h000C
`define TWX_TEST_SKIP_MASK 16'hFE00
`define TWX_TEST_SKIP_CODE 16'h6600
`define TWX_XOR_LITERAL_MASK 16'hFF00
`define TWX_XOR_LITERAL_CODE 16'h0A00
`define TWX_XOR_FILE_MASK 16'hFC00
`define TWX_XOR_FILE_CODE 16'h1800

// pointer update modes
`define TWX_MODE_KEEP 2'h0
`define TWX_MODE_POSTINC 2'h1
`define TWX_MODE_POSTDEC 2'h2
`define TWX_MODE_PREINC 2'h3

// quarter phases of one instruction cycle
`define TWX_Q1 2'h0
`define TWX_Q2 2'h1
`define TWX_Q3 2'h2
`define TWX_Q4 2'h3

// misc values
`define TWX_ACCESS_BANK 4'h0
`define TWX_PTR_ONE 21'h00_0001
`define TWX_RESP_OKAY 2'h0
`define TWX_RESP_SLVERR 2'h2
`define TWX_RESP_DECERR 2'h3

`endif

// [twx_pkg.sv]
// types for the table write / test-skip / xor execution block
package twx_pkg;

	typedef enum logic [1:0] {st_idle, st_exec, st_wait} twx_state_type;

	typedef enum logic [2:0] {
		kind_none,
		kind_table_write_op,
		kind_test_file_skip_zero_op,
		kind_xor_literal_op,
		kind_xor_file_op
	} twx_kind_type;

	typedef struct packed {
		twx_state_type st;
		twx_kind_type kind;
		logic [15:0] instr;
		logic [15:0] next;
		logic next_two;
		logic [1:0] ph;
		logic [3:0] cyc;
		logic [7:0] working_register;
		logic [3:0] bank_select_register;
		logic [20:0] ptr;
		logic [7:0] table_byte_latch;
		logic long_wr;
		logic flag_n;
		logic flag_z;
		logic skip;
		logic illegal;
		logic [3:0] last_cyc;
		logic [15:0] hold;
		logic [11:0] file_addr;
		logic [7:0] operand;
		logic pm_we;
		logic [20:0] pm_addr;
		logic [7:0] pm_data;
		logic aw_got;
		logic [7:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} twx_regs_type;

endpackage

// [twx_file_mem.sv]
// file register memory, 4096 bytes, one port with registered read data
`timescale 1ns/1ps
module twx_file_mem (
	input wire logic aclk,
	input wire logic [11:0] addr,
	input wire logic we,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:4095];

	// write on the edge, read data registered one edge after the address
	always_ff @(posedge aclk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule

// [twx_core.sv]
// execution of table write, test-skip-if-zero and the two xor instructions
// Operation
// - the word 0000_0000_0000_11nn is decoded as table write with mode nn.
// - table write moves the table byte latch to program memory or to the holding register.
// - the program byte pointer is a 21-bit byte address over a two megabyte space.
// - pointer bit zero picks the low byte (0) or the high byte (1) of a program word.
// - mode 0 keeps the pointer, 1 post-increments, 2 post-decrements, 3 pre-increments.
// - table write takes one word and two cycles, touches no flag, and stalls on a long write.
// - 0110_011a_ffff_ffff is decoded as test-file-skip-if-zero.
// - a zero file value discards the next word as a no-operation, two cycles, no flags.
// - a skip over a two-word instruction takes three cycles in total.
// - access bit 0 forces the access bank, access bit 1 uses the bank select register.
// - 0000_1010_kkkk_kkkk is decoded as xor-literal with literal k.
// - xor-literal puts working register xor k back in the working register in one cycle.
// - 0001_10da_ffff_ffff is decoded as xor-with-file.
// - xor-with-file writes the file when d is 1, else the working register, Q2 read, Q4 write.
// - both xor instructions change only the negative and zero flags.
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "twx_params.svh"
module twx_core
	import twx_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic pm_we,
	output logic [20:0] pm_addr,
	output logic [7:0] pm_data,
	input wire logic pm_done,
	output logic busy
);
	twx_regs_type q;
	twx_regs_type d;
	logic [11:0] mem_addr;
	logic mem_we;
	logic [7:0] mem_wdata;
	logic [7:0] mem_rdata;

	// opcode classification
	function automatic twx_kind_type decode(input logic [15:0] w);
		twx_kind_type k;
		k = kind_none;
		if ((w & `TWX_TABLE_WRITE_MASK) == `TWX_TABLE_WRITE_CODE) begin
			k = kind_table_write_op;
		end else if ((w & `TWX_TEST_SKIP_MASK) == `TWX_TEST_SKIP_CODE) begin
			k = kind_test_file_skip_zero_op;
		end else if ((w & `TWX_XOR_LITERAL_MASK) == `TWX_XOR_LITERAL_CODE) begin
			k = kind_xor_literal_op;
		end else if ((w & `TWX_XOR_FILE_MASK) == `TWX_XOR_FILE_CODE) begin
			k = kind_xor_file_op;
		end
		return k;
	endfunction

	// byte-lane merge of a bus write into an old register value
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// register read mux; bit 32 flags a mapped offset
	function automatic logic [32:0] reg_value(input twx_regs_type r, input logic [7:0] a,
		input logic [7:0] fdata);
		logic [32:0] v;
		v = 33'h0_0000_0000;
		unique case (a)
			`TWX_OFF_INSTR: v = {17'h1_0000, r.instr};
			`TWX_OFF_NEXT: v = {16'h8000, r.next_two, r.next};
			`TWX_OFF_WORKING_REGISTER: v = {25'h100_0000, r.working_register};
			`TWX_OFF_BANK_SELECT: v = {29'h1000_0000, r.bank_select_register};
			`TWX_OFF_PTR: v = {12'h800, r.ptr};
			`TWX_OFF_TABLE_BYTE_LATCH: v = {25'h100_0000, r.table_byte_latch};
			`TWX_OFF_CTRL: v = {32'h8000_0000, r.long_wr};
			`TWX_OFF_STATUS: v = {21'h10_0000, r.last_cyc, 3'h0, r.illegal, r.skip,
				r.flag_z, r.flag_n, (r.st != st_idle)};
			`TWX_OFF_HOLD: v = {17'h1_0000, r.hold};
			`TWX_OFF_FADDR: v = {21'h10_0000, r.file_addr};
			`TWX_OFF_FDATA: v = {25'h100_0000, fdata};
			default: v = 33'h0_0000_0000;
		endcase
		return v;
	endfunction

	twx_file_mem u_mem (
		.aclk(aclk),
		.addr(mem_addr),
		.we(mem_we),
		.wdata(mem_wdata),
		.rdata(mem_rdata)
	);

	// next-state logic: instruction sequencer then bus slave
	always_comb begin
		logic [7:0] res;
		logic [11:0] faddr;
		logic last_q;
		logic [20:0] ptr_inc;
		logic [32:0] rv;
		logic [31:0] mv;
		logic [1:0] mode;
		res = 8'h00;
		faddr = 12'h000;
		last_q = 1'b0;
		ptr_inc = 21'h00_0000;
		rv = 33'h0_0000_0000;
		mv = 32'h0000_0000;
		mode = 2'h0;
		d = q;
		d.pm_we = 1'b0;
		mem_addr = q.file_addr;
		mem_we = 1'b0;
		mem_wdata = 8'h00;
		res = q.working_register ^ q.operand;
		mode = q.instr[1:0];
		ptr_inc = q.ptr + `TWX_PTR_ONE; // 21-bit wrap over the byte space
		last_q = (q.ph == `TWX_Q4);
		// bank choice for file operands
		faddr = q.instr[`TWX_ACC_BIT] ? {q.bank_select_register, q.instr[7:0]}
			: {`TWX_ACCESS_BANK, q.instr[7:0]};
		unique case (q.st)
			st_idle: begin
			end
			st_exec: begin
				d.ph = q.ph + 2'h1;
				if (last_q) begin
					d.cyc = q.cyc + 4'h1;
				end
				unique case (q.kind)
					kind_xor_literal_op: begin
						if (q.ph == `TWX_Q2) begin
							d.operand = q.instr[7:0]; // literal read
						end
						if (last_q) begin
							d.working_register = res;
							d.flag_n = res[7];
							d.flag_z = (res == 8'h00);
							d.st = st_idle;
							d.last_cyc = q.cyc + 4'h1;
						end
					end
					kind_xor_file_op: begin
						mem_addr = faddr;
						if (q.ph == `TWX_Q2) begin
							d.operand = mem_rdata; // file read in Q2
						end
						if (last_q) begin
							if (q.instr[`TWX_DEST_BIT]) begin
								mem_we = 1'b1; // write back to file in Q4
								mem_wdata = res;
							end else begin
								d.working_register = res;
							end
							d.flag_n = res[7];
							d.flag_z = (res == 8'h00);
							d.st = st_idle;
							d.last_cyc = q.cyc + 4'h1;
						end
					end
					kind_test_file_skip_zero_op: begin
						mem_addr = faddr;
						if (q.ph == `TWX_Q2 && q.cyc == 4'h0) begin
							d.operand = mem_rdata;
						end
						if (last_q) begin
							if (q.cyc == 4'h0 && q.operand != 8'h00) begin
								d.st = st_idle; // no skip, one cycle
								d.last_cyc = 4'h1;
							end else if (q.cyc == 4'h0) begin
								d.skip = 1'b1; // next word becomes a no-operation
							end else if (q.cyc == 4'h1 && !q.next_two) begin
								d.st = st_idle;
								d.last_cyc = 4'h2;
							end else if (q.cyc == 4'h2) begin
								d.st = st_idle; // second word also discarded
								d.last_cyc = 4'h3;
							end
						end
					end
					kind_table_write_op: begin
						if (last_q && q.cyc == 4'h0 && mode == `TWX_MODE_PREINC) begin
							d.ptr = ptr_inc; // pre-increment ahead of the access
						end
						if (q.ph == `TWX_Q2 && q.cyc == 4'h1) begin
							d.operand = q.table_byte_latch; // latch read in Q2
						end
						if (last_q && q.cyc == 4'h1) begin
							if (q.long_wr) begin
								d.pm_we = 1'b1; // long write to program memory
								d.pm_addr = q.ptr;
								d.pm_data = q.operand;
								d.st = st_wait; // stall until the write completes
							end else begin
								d.st = st_idle; // two cycles
								d.last_cyc = 4'h2;
								if (q.ptr[0]) begin
									d.hold[15:8] = q.operand; // high byte
								end else begin
									d.hold[7:0] = q.operand; // low byte
								end
							end
							if (mode == `TWX_MODE_POSTINC) begin
								d.ptr = ptr_inc;
							end else if (mode == `TWX_MODE_POSTDEC) begin
								d.ptr = q.ptr - `TWX_PTR_ONE;
							end
						end
					end
					kind_none: begin
						if (last_q) begin
							d.illegal = 1'b1; // unknown word retires as a no-operation
							d.st = st_idle;
							d.last_cyc = 4'h1;
						end
					end
				endcase
			end
			st_wait: begin
				if (pm_done) begin
					d.st = st_idle;
					d.last_cyc = q.cyc;
				end
			end
		endcase

		// axi4-lite write address and data capture, either order
		if (s_axi_awvalid && !q.aw_got && !q.bvalid) begin
			d.aw_got = 1'b1;
			d.awaddr = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && !q.w_got && !q.bvalid) begin
			d.w_got = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		// write commit once both halves are held
		if (q.aw_got && q.w_got) begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = `TWX_RESP_OKAY;
			rv = reg_value(q, q.awaddr, mem_rdata);
			mv = merge(rv[31:0], q.wdata, q.wstrb);
			if (!rv[32]) begin
				d.bresp = `TWX_RESP_DECERR;
			end else if (q.st != st_idle) begin
				d.bresp = `TWX_RESP_SLVERR; // no change while an instruction runs
			end else begin
				unique case (q.awaddr)
					`TWX_OFF_INSTR: begin
						d.instr = mv[15:0];
						d.kind = decode(mv[15:0]);
						d.st = st_exec;
						d.ph = `TWX_Q1;
						d.cyc = 4'h0;
						d.skip = 1'b0;
						d.illegal = 1'b0;
					end
					`TWX_OFF_NEXT: begin
						d.next = mv[15:0];
						d.next_two = mv[`TWX_NEXT_TWO_BIT];
					end
					`TWX_OFF_WORKING_REGISTER: d.working_register = mv[7:0];
					`TWX_OFF_BANK_SELECT: d.bank_select_register = mv[3:0];
					`TWX_OFF_PTR: d.ptr = mv[20:0];
					`TWX_OFF_TABLE_BYTE_LATCH: d.table_byte_latch = mv[7:0];
					`TWX_OFF_CTRL: d.long_wr = mv[`TWX_CTRL_LONG_BIT];
					`TWX_OFF_FADDR: d.file_addr = mv[11:0];
					`TWX_OFF_FDATA: begin
						mem_we = q.wstrb[0];
						mem_wdata = mv[7:0];
					end
					default: d.bresp = `TWX_RESP_SLVERR; // read-only offsets
				endcase
			end
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end

		// axi4-lite read, answered one edge after the address is taken
		if (s_axi_arvalid && !q.rvalid) begin
			rv = reg_value(q, s_axi_araddr[7:0], mem_rdata);
			d.rvalid = 1'b1;
			d.rdata = rv[31:0];
			d.rresp = rv[32] ? `TWX_RESP_OKAY : `TWX_RESP_DECERR;
		end else if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
	end

	// state register, synchronous active-low reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// port drive
	assign s_axi_awready = !q.aw_got && !q.bvalid;
	assign s_axi_wready = !q.w_got && !q.bvalid;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = !q.rvalid;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign pm_we = q.pm_we;
	assign pm_addr = q.pm_addr;
	assign pm_data = q.pm_data;
	assign busy = (q.st != st_idle);
endmodule

// [twx_checker.sv]
// port assertions for the execution block
`timescale 1ns/1ps
module twx_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic pm_we,
	input wire logic pm_done,
	input wire logic busy
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// long write request and stall
	we_pulse_a: assert property (pm_we |=> !pm_we)
		else $error("write request wider than one cycle");
	we_busy_a: assert property (pm_we |-> busy)
		else $error("write request while idle");
	done_idle_a: assert property (busy && pm_done |=> !busy)
		else $error("still busy after write done");
	we_late_a: assert property (pm_we |-> $past(busy, 8))
		else $error("write request before second cycle ended");
	// one instruction cycle is four clocks
	cycle_len_a: assert property ($rose(busy) |-> busy [*4])
		else $error("instruction shorter than one cycle");
	// bus handshakes
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	wresp_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write answer late");
endmodule
bind twx_core twx_checker chk_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.pm_we, .pm_done, .busy);

// [twx_pm_model.sv]
// program memory write path answering long write requests
`timescale 1ns/1ps
module twx_pm_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pm_we,
	input wire logic [20:0] pm_addr,
	input wire logic [7:0] pm_data,
	input wire logic [7:0] delay,
	output logic pm_done
);
	logic [20:0] wr_addr;
	logic [7:0] wr_data;
	int cnt;
	// keep the last byte written, then pulse done after the chosen delay
	always @(posedge aclk) begin
		pm_done <= aresetn && !pm_we && cnt == 1;
		if (!aresetn) begin
			cnt <= 0;
		end else if (pm_we) begin
			wr_addr <= pm_addr;
			wr_data <= pm_data;
			cnt <= delay + 1;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
	end
endmodule

// [tb.sv]
// self-checking bench for the execution block
`timescale 1ns/1ps
`include "twx_params.svh"
module tb;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pm_done;
	logic awready, wready, bvalid, arready, rvalid, pm_we, busy;
	logic [31:0] awaddr, wdata, araddr, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [20:0] pm_addr;
	logic [7:0] pm_data, dly;
	int seed, err_count, n_compared, cycles, i, m, w, k, v, f, fa, res, p, q, t, hold, n, z;
	int busy_run = 0, last_run = 0;
	twx_core dut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.pm_we, .pm_addr, .pm_data, .pm_done, .busy);
	twx_pm_model pm (.aclk, .aresetn, .pm_we, .pm_addr, .pm_data, .delay(dly), .pm_done);
	// compare and report
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// bus write, ready late on purpose at random
	task automatic wr(input logic [7:0] a, input logic [31:0] x, output logic [1:0] rs);
		@(posedge aclk);
		awaddr <= 32'(a);
		wdata <= x;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'($random(seed));
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			bready <= 1'b1;
		end while (!(bvalid && bready));
		rs = bresp;
		bready <= 1'b0;
	endtask
	// bus read
	task automatic rd(input logic [7:0] a, output logic [31:0] x, output logic [1:0] rs);
		@(posedge aclk);
		araddr <= 32'(a);
		arvalid <= 1'b1;
		rready <= 1'($random(seed));
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			rready <= 1'b1;
		end while (!(rvalid && rready));
		x = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
		rd(a, d, r);
		chk(nm, d, exp);
	endtask
	task automatic idle();
		do rd(`TWX_OFF_STATUS, d, r);
		while (d[0] === 1'b1);
	endtask
	task automatic exec(input logic [31:0] ins);
		wr(`TWX_OFF_INSTR, ins, r);
		idle();
	endtask
	task automatic st(input int cyc, input int sk, input int il);
		rchk(`TWX_OFF_STATUS, cyc << 8 | il << 4 | sk << 3 | z << 2 | n << 1, "status");
	endtask
	task automatic nz(input int x);
		n = x >> 7 & 1;
		z = x == 0;
	endtask
	// reference table write: pointer update and holding byte
	task automatic tw(input int md);
		if (md == 3) p = (p + 1) & 21'h1f_ffff;
		q = p;
		if (p & 1) hold = hold & 255 | t << 8;
		else hold = hold & 16'hff00 | t;
		if (md == 1) p = (p + 1) & 21'h1f_ffff;
		if (md == 2) p = (p - 1) & 21'h1f_ffff;
	endtask
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// hang guard, and the length in clocks of the last busy stretch
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		busy_run <= busy ? busy_run + 1 : 0;
		if (!busy && busy_run != 0) last_run <= busy_run;
		if (cycles == 30000) begin
			err_count = err_count + 1;
			finish_test();
		end
	end
	initial begin
		seed = 32'h4ed0;
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, wdata, araddr} = '0;
		wstrb = 4'hf;
		dly = 8'h00;
		{err_count, n_compared, cycles, n, z, hold} = '0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		// xor literal, the first giving zero
		for (i = 0; i < 6; i++) begin
			w = $random(seed) & 255;
			k = i ? $random(seed) & 255 : w;
			wr(`TWX_OFF_WORKING_REGISTER, w, r);
			exec(16'h0a00 | k);
			w = w ^ k;
			nz(w);
			rchk(`TWX_OFF_WORKING_REGISTER, w, "working register");
			st(1, 0, 0);
			chk("busy length", last_run, 4);
		end
		// xor with file for every destination and access bit
		for (i = 0; i < 4; i++) begin
			k = ($random(seed) & 7) + 1;
			f = $random(seed) & 255;
			v = $random(seed) & 255;
			w = $random(seed) & 255;
			fa = i[0] ? k * 256 + f : f;
			wr(`TWX_OFF_BANK_SELECT, k, r);
			wr(`TWX_OFF_FADDR, fa, r);
			wr(`TWX_OFF_FDATA, v, r);
			wr(`TWX_OFF_WORKING_REGISTER, w, r);
			exec(16'h1800 | i << 8 | f);
			res = v ^ w;
			nz(res);
			if (i[1]) v = res;
			else w = res;
			rchk(`TWX_OFF_WORKING_REGISTER, w, "working register");
			rchk(`TWX_OFF_FDATA, v, "file");
			st(1, 0, 0);
		end
		// test for zero; the fetched word must never run
		for (i = 0; i < 4; i++) begin
			f = 8'h40 + i;
			wr(`TWX_OFF_FADDR, f, r);
			wr(`TWX_OFF_FDATA, i[0] ? 0 : 8'h80 + i, r);
			wr(`TWX_OFF_NEXT, (i >> 1) << 16 | 16'h0a55, r);
			exec(16'h6600 | f);
			rchk(`TWX_OFF_WORKING_REGISTER, w, "working register");
			st(i[0] ? 2 + (i >> 1) : 1, i[0], 0);
			chk("busy length", last_run, 4 * (i[0] ? 2 + (i >> 1) : 1));
		end
		// holding register writes in every mode, at the wrap points in modes 1 to 3
		wr(`TWX_OFF_CTRL, 0, r);
		for (m = 0; m < 4; m++) begin
			p = m[0] ? 21'h1f_ffff : (m == 2 ? 0 : $random(seed) & 21'h1f_ffff);
			t = $random(seed) & 255;
			wr(`TWX_OFF_PTR, p, r);
			wr(`TWX_OFF_TABLE_BYTE_LATCH, t, r);
			exec(16'h000c | m);
			tw(m);
			rchk(`TWX_OFF_PTR, p, "pointer");
			rchk(`TWX_OFF_HOLD, hold, "holding");
			st(2, 0, 0);
			chk("busy length", last_run, 8);
		end
		// long writes, slow then prompt partner, a write refused meanwhile
		wr(`TWX_OFF_CTRL, 1, r);
		for (m = 0; m < 2; m++) begin
			dly <= m ? 8'h00 : 8'h14;
			p = $random(seed) & 21'h1f_ffff;
			t = $random(seed) & 255;
			wr(`TWX_OFF_PTR, p, r);
			wr(`TWX_OFF_TABLE_BYTE_LATCH, t, r);
			wr(`TWX_OFF_INSTR, 16'h000f - m * 2, r);
			wr(`TWX_OFF_WORKING_REGISTER, 0, r);
			chk("busy write", r, `TWX_RESP_SLVERR);
			idle();
			tw(3 - m * 2);
			chk("program address", pm.wr_addr, q);
			chk("program byte", pm.wr_data, t);
			rchk(`TWX_OFF_PTR, p, "pointer");
			st(2, 0, 0);
		end
		// unmapped read, read-only write, unknown word
		rd(8'hfc, d, r);
		chk("unmapped", r, `TWX_RESP_DECERR);
		wr(`TWX_OFF_STATUS, 0, r);
		chk("read-only", r, `TWX_RESP_SLVERR);
		exec(16'hffff);
		st(1, 0, 1);
		finish_test();
	end
endmodule
